// [hdl/mie_exec.v]
`include "mie_map.vh"
`default_nettype none
module mie_exec (
	// clock and reset
	input  wire                    clk_sys,
	input  wire                    arst_n,
	// instruction issue
	input  wire                    op_valid,
	input  wire [2:0]              op_code,
	input  wire                    op_sleep,
	input  wire [7:0]              op_literal,
	input  wire [6:0]              op_addr,
	input  wire                    op_dest,
	output wire                    op_ready,
	// call stack push from outside
	input  wire                    push_valid,
	input  wire [12:0]             push_addr,
	// watchdog tick
	input  wire                    wdt_tick,
	// wake from sleep
	input  wire                    wake,
	// file register read port
	output wire [6:0]              file_rd_addr,
	input  wire [7:0]              file_rd_data,
	// file register write port
	output reg                     file_wr_en_ff,
	output reg  [6:0]              file_wr_addr_ff,
	output reg  [7:0]              file_wr_data_ff,
	// architectural state
	output reg  [7:0]              acc_ff,
	output reg                     carry_ff,
	output reg  [12:0]             pc_ff,
	output reg                     irq_master_enable_ff,
	output reg                     timeout_flag_n_ff,
	output reg                     sleep_entered_flag_n_ff,
	output reg  [7:0]              watchdog_counter_ff,
	output reg  [7:0]              prescaler_ff,
	output reg                     sleeping_ff,
	output reg                     osc_run_ff
);
	// the stack is a circular array: overflow silently overwrites the oldest entry
	reg  [12:0] stack_mem [0:`MIE_STACK_DEPTH-1];
	reg  [2:0]  sp_ff;
	reg  [1:0]  busy_ff;
	wire [7:0]  rot_res;
	wire        rot_carry;
	wire [2:0]  sp_top;
	wire        take;
	integer     i;
	// decoded issue strobes and the ungated rotate direction
	wire        pop_take;
	wire        sleep_take;
	wire        rot_left;

	function [12:0] pc_inc;
		input [12:0] pc;
		begin
			pc_inc = pc + 13'h0001;
		end
	endfunction

	// the three returns share the pop and the hold-off cycle
	function is_return;
		input [2:0] code;
		begin
			is_return = (code == `MIE_OP_RET) ||
				(code == `MIE_OP_RET_LIT) ||
				(code == `MIE_OP_IRQ_RET);
		end
	endfunction

	assign sp_top       = sp_ff - 3'h1;
	assign file_rd_addr = op_addr;
	// a second cycle of a return blocks the next issue
	assign op_ready     = !sleeping_ff && (busy_ff == 2'h0);
	assign take         = op_valid && op_ready;
	assign pop_take     = take && !op_sleep && is_return(op_code);
	assign sleep_take   = take && op_sleep;
	assign rot_left     = (op_code == `MIE_OP_ROT_LEFT);

	mie_rotate u_rot (
		.src_val   (file_rd_data),
		.carry_in  (carry_ff),
		.dir_left  (rot_left),
		.res_val   (rot_res),
		.carry_out (rot_carry)
	);

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			acc_ff                  <= `MIE_ACC_RST;
			carry_ff                <= 1'b0;
			pc_ff                   <= `MIE_PC_RST;
			irq_master_enable_ff    <= 1'b0;
			timeout_flag_n_ff       <= `MIE_TO_N_RST;
			sleep_entered_flag_n_ff <= `MIE_PD_N_RST;
			file_wr_en_ff           <= 1'b0;
			file_wr_addr_ff         <= 7'h00;
			file_wr_data_ff         <= 8'h00;
		end else begin
			file_wr_en_ff <= 1'b0;
			if (sleep_take) begin
				timeout_flag_n_ff       <= 1'b1;
				sleep_entered_flag_n_ff <= 1'b0;
				pc_ff                   <= pc_inc(pc_ff);
			end else if (take) begin
				case (op_code)
					`MIE_OP_NOP: begin
						pc_ff <= pc_inc(pc_ff);
					end
					`MIE_OP_LOAD_LIT: begin
						acc_ff <= op_literal;
						pc_ff  <= pc_inc(pc_ff);
					end
					`MIE_OP_STORE_ACC: begin
						file_wr_en_ff   <= 1'b1;
						file_wr_addr_ff <= op_addr;
						file_wr_data_ff <= acc_ff;
						pc_ff           <= pc_inc(pc_ff);
					end
					`MIE_OP_RET: begin
						pc_ff   <= stack_mem[sp_top];
					end
					`MIE_OP_RET_LIT: begin
						acc_ff  <= op_literal;
						pc_ff   <= stack_mem[sp_top];
					end
					`MIE_OP_IRQ_RET: begin
						pc_ff                <= stack_mem[sp_top];
						irq_master_enable_ff <= 1'b1;
					end
					`MIE_OP_ROT_LEFT, `MIE_OP_ROT_RIGHT: begin
						carry_ff <= rot_carry;
						if (op_dest) begin
							file_wr_en_ff   <= 1'b1;
							file_wr_addr_ff <= op_addr;
							file_wr_data_ff <= rot_res;
						end else begin
							acc_ff <= rot_res;
						end
						pc_ff <= pc_inc(pc_ff);
					end
					default: begin
						pc_ff <= pc_inc(pc_ff);
					end
				endcase
			end
		end
	end

	// a taken return holds off the next issue for one cycle
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			busy_ff <= 2'h0;
		end else if (pop_take) begin
			busy_ff <= `MIE_CYC_TWO - 2'h1;
		end else if (busy_ff != 2'h0) begin
			busy_ff <= busy_ff - 2'h1;
		end
	end

	// stack storage; overflow wraps and overwrites the oldest entry
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sp_ff <= 3'h0;
			for (i = 0; i < `MIE_STACK_DEPTH; i = i + 1) begin
				stack_mem[i] <= `MIE_PC_RST;
			end
		end else if (pop_take) begin
			sp_ff <= sp_top;
		end else if (push_valid && !take) begin
			// a push alongside a taken op is dropped
			stack_mem[sp_ff] <= push_addr;
			sp_ff            <= sp_ff + 3'h1;
		end
	end

	// prescaler counts ticks; a sleep clear beats a tick in the same cycle
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			watchdog_counter_ff <= `MIE_WDT_CLR;
			prescaler_ff        <= `MIE_PRE_CLR;
		end else if (sleep_take) begin
			watchdog_counter_ff <= `MIE_WDT_CLR;
			prescaler_ff        <= `MIE_PRE_CLR;
		end else if (wdt_tick && !sleeping_ff) begin
			// ticks are ignored while the oscillator is stopped
			prescaler_ff <= prescaler_ff + 8'h01;
			if (prescaler_ff == 8'hFF) begin
				watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
			end
		end
	end

	// sleep halts issue until wake; the oscillator restarts with it
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sleeping_ff <= 1'b0;
			osc_run_ff  <= 1'b1;
		end else if (sleep_take) begin
			sleeping_ff <= 1'b1;
			osc_run_ff  <= 1'b0;
		end else if (sleeping_ff && wake) begin
			sleeping_ff <= 1'b0;
			osc_run_ff  <= 1'b1;
		end
	end
endmodule // mie_exec
`default_nettype wire

// [hdl/mie_map.vh]
`ifndef MIE_MAP_VH
`define MIE_MAP_VH
// operation codes presented on op_code
`define MIE_OP_NOP        3'h0
`define MIE_OP_LOAD_LIT   3'h1
`define MIE_OP_STORE_ACC  3'h2
`define MIE_OP_RET        3'h3
`define MIE_OP_RET_LIT    3'h4
`define MIE_OP_IRQ_RET    3'h5
`define MIE_OP_ROT_LEFT   3'h6
`define MIE_OP_ROT_RIGHT  3'h7
// widths
`define MIE_DATA_W        8
`define MIE_ADDR_W        7
`define MIE_PC_W          13
`define MIE_SP_W          3
`define MIE_STACK_DEPTH   8
`define MIE_WDT_W         8
`define MIE_PRE_W         8
// timing in instruction cycles
`define MIE_CYC_ONE       2'h1
`define MIE_CYC_TWO       2'h2
// reset values
`define MIE_ACC_RST       8'h00
`define MIE_PC_RST        13'h0000
`define MIE_TO_N_RST      1'b1
`define MIE_PD_N_RST      1'b1
`define MIE_WDT_CLR       8'h00
`define MIE_PRE_CLR       8'h00
`endif

// [hdl/mie_rotate.v]
`default_nettype none
module mie_rotate (
	// operand, carry in and direction
	input  wire [7:0] src_val,
	input  wire       carry_in,
	input  wire       dir_left,
	// result and carry out
	output reg  [7:0] res_val,
	output reg        carry_out
);
	always @* begin
		if (dir_left) begin
			res_val   = {src_val[6:0], carry_in};
			carry_out = src_val[7];
		end else begin
			res_val   = {carry_in, src_val[7:1]};
			carry_out = src_val[0];
		end
	end
endmodule // mie_rotate
`default_nettype wire

// [bench/mie_exec_props.sv]
`default_nettype none
module mie_exec_props (
	input wire logic       clk_sys, arst_n, op_valid, op_sleep, op_dest, op_ready, carry_ff,
	input wire logic       file_wr_en_ff, irq_master_enable_ff, sleeping_ff, osc_run_ff,
	input wire logic       timeout_flag_n_ff, sleep_entered_flag_n_ff,
	input wire logic [2:0] op_code,
	input wire logic [7:0] op_literal, file_rd_data, file_wr_data_ff, acc_ff, watchdog_counter_ff
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// sleep overrides op_code, so it stays out of the plain issue term
	wire tk = op_valid && op_ready && !op_sleep;
	sequence s_gap; !op_ready ##1 op_ready; endsequence
	property p_load; tk && op_code == 3'h1 |=> acc_ff == $past(op_literal); endproperty
	a_load: assert property (p_load) else $error("load wrong");
	property p_store; tk && op_code == 3'h2 |=> file_wr_en_ff && file_wr_data_ff == $past(acc_ff);
	endproperty
	a_store: assert property (p_store) else $error("store wrong");
	property p_rlit; tk && op_code == 3'h4 |=> acc_ff == $past(op_literal) ##0 s_gap; endproperty
	a_rlit: assert property (p_rlit) else $error("literal return wrong");
	property p_gie; tk && op_code == 3'h5 |=> irq_master_enable_ff ##0 s_gap; endproperty
	a_gie: assert property (p_gie) else $error("irq return wrong");
	property p_rotl; tk && op_code == 3'h6 && !op_dest |=>
		{carry_ff, acc_ff} == {$past(file_rd_data), $past(carry_ff)}; endproperty
	a_rotl: assert property (p_rotl) else $error("rotate left wrong");
	property p_rotr; tk && op_code == 3'h7 && op_dest |=> file_wr_en_ff &&
		{file_wr_data_ff, carry_ff} == {$past(carry_ff), $past(file_rd_data)}; endproperty
	a_rotr: assert property (p_rotr) else $error("rotate right wrong");
	property p_sleep; op_valid && op_ready && op_sleep |=> watchdog_counter_ff == 8'h00 &&
		timeout_flag_n_ff && !sleep_entered_flag_n_ff && sleeping_ff; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
	property p_halt; sleeping_ff |-> !op_ready && !osc_run_ff; endproperty
	a_halt: assert property (p_halt) else $error("sleep not halted");
endmodule // mie_exec_props
bind mie_exec mie_exec_props mie_exec_props_inst (.*);
`default_nettype wire

// [bench/mie_exec_tb_top.sv]
`default_nettype none
module mie_exec_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys = 0, arst_n = 0, op_valid = 0, op_sleep = 0, op_dest = 0, wake = 0;
	logic        push_valid = 0, wdt_tick = 0, op_ready, file_wr_en_ff, carry_ff, osc_run_ff;
	logic        irq_master_enable_ff, timeout_flag_n_ff, sleep_entered_flag_n_ff, sleeping_ff;
	logic [2:0]  op_code = 0;
	logic [6:0]  op_addr = 0, file_rd_addr, file_wr_addr_ff;
	logic [7:0]  op_literal = 0, file_rd_data = 0, acc_ff, file_wr_data_ff, m_acc = 0;
	logic [7:0]  watchdog_counter_ff, prescaler_ff;
	logic [12:0] push_addr = 0, pc_ff, m_pc = 0, stk [$];
	logic [14:0] m_w;
	logic [31:0] lf = 32'h73DFFCB7, r;
	logic [8:0]  t;
	logic        m_c = 0, m_gie = 0, m_we = 0, rt;
	int          failures = 0, compares = 0, cyc = 0;
	mie_exec mie_exec_inst (.*);
	always #2.5 clk_sys = ~clk_sys;
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction
	task chk(input string nm, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) failures++;
		if (seen !== exp) $display("FAIL %s expected %h seen %h", nm, exp, seen);
	endtask
	task verify();
		@(negedge clk_sys);
		chk("acc_carry", {acc_ff, carry_ff}, {m_acc, m_c});
		chk("pc_gie_we", {pc_ff, irq_master_enable_ff, file_wr_en_ff}, {m_pc, m_gie, m_we});
		if (m_we) chk("wr", {file_wr_addr_ff, file_wr_data_ff}, m_w);
		chk("rd_addr", file_rd_addr, op_addr);
	endtask
	task run(input logic [2:0] cd, input logic sl);
		r = rnd();
		rt = !sl && cd inside {[3'h3:3'h5]};
		verify();
		{push_valid, op_valid, op_code, op_sleep, op_literal, file_rd_data, op_dest, op_addr} =
			{2'h1, cd, sl, r[23:0]};
		wdt_tick = r[24] & !sl;
		@(posedge clk_sys);
		t = cd[0] ? {r[8], m_c, r[15:9]} : {r[15:8], m_c};
		m_we = !sl && (cd == 3'h2 || cd > 3'h5 && r[7]);
		m_w = {r[6:0], cd == 3'h2 ? m_acc : t[7:0]};
		case (sl ? 3'h0 : cd)
			3'h1, 3'h4: m_acc = r[23:16];
			3'h6, 3'h7: {m_c, m_acc} = {t[8], r[7] ? m_acc : t[7:0]};
		endcase
		m_gie |= rt && cd == 3'h5;
		m_pc = rt ? stk.pop_back() : m_pc + 13'h1;
		// a return left waiting must be refused, so this literal never lands
		if (rt) begin
			verify();
			op_literal = ~m_acc;
			@(posedge clk_sys);
		end
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		arst_n = 1;
		repeat (400) begin
			r = rnd();
			// stack held to eight entries: the circular wrap is left unexercised
			if (r[3] && stk.size() < 8 || r[2:0] inside {[3:5]} && stk.size() == 0) begin
				verify();
				{op_valid, push_valid, push_addr} = {2'h1, r[20:8]};
				stk.push_back(push_addr);
				m_we = 0;
				@(posedge clk_sys);
			end else run(r[2:0], 1'b0);
		end
		run(3'h0, 1'b1);
		verify();
		chk("wdt_pre", {watchdog_counter_ff, prescaler_ff}, 16'h0);
		chk("to_pd", {timeout_flag_n_ff, sleep_entered_flag_n_ff}, 2'h2);
		chk("halt", {sleeping_ff, osc_run_ff, op_ready}, 3'h4);
		{op_valid, wake} = 2'h1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		wake = 0;
		chk("wake", {sleeping_ff, osc_run_ff, op_ready}, 3'h3);
		final_report();
	end
	always @(posedge clk_sys) if (++cyc == 5000) begin
		failures++;
		final_report();
	end
	task final_report();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
endmodule // mie_exec_tb_top
`default_nettype wire
